/* design/tcmp_pkg.sv */
// package: register map, fields and constants of the compare timer
package tcmp_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SYSCTL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_OUTCTL1 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OUTCTL2 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PINCFG = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CMP_BASE = 8'h20;

  // system control field positions
  localparam int SC_RUN_BIT = 7;
  localparam int SC_WAITSTOP_BIT = 6;
  localparam logic [7:0] SC_IMPL_MASK = 8'hC0;

  // pin config: low byte mask, high byte disconnect
  localparam int PC_MASK_LSB = 0;
  localparam int PC_DISC_LSB = 8;

  // reset values
  localparam logic [7:0] SYSCTL_RST = 8'h00;
  localparam logic [7:0] OUTCTL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] DISC_RST = 8'h00;
  localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;

  // timing
  localparam int PRESCALE_DIV = 1;
  localparam int ACC_DIV = 64;

  // pin actions, encoded {mode,level}
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* design/tcmp_prescaler.sv */
// prescaler: count tick and divide-by-64 accumulator clock
`timescale 1ns/10ps
module tcmp_prescaler #(
  parameter int DIV = tcmp_pkg::PRESCALE_DIV,
  parameter int ACC = tcmp_pkg::ACC_DIV
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic active,
  output logic tick,
  output logic accTick
);
  import tcmp_pkg::*;

  typedef struct packed {
    logic [15:0] pre;
    logic [15:0] acc;
    logic accTick;
  } pre_s;

  pre_s st_q;
  pre_s st_d;

  // tick is the terminal count of the prescaler
  assign tick = active && (st_q.pre == 16'((DIV > 0 ? DIV : 1) - 1));
  assign accTick = st_q.accTick;

  // prescaler halts with the timer, so the accumulator clock stops too
  always_comb begin
    st_d = st_q;
    st_d.accTick = 1'b0;
    if (active) begin
      if (tick) begin
        st_d.pre = 16'h0000;
        if (st_q.acc == 16'(ACC - 1)) begin
          st_d.acc = 16'h0000;
          st_d.accTick = 1'b1;
        end else begin
          st_d.acc = st_q.acc + 16'h0001;
        end
      end else begin
        st_d.pre = st_q.pre + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end
endmodule

/* design/tcmp_channel.sv */
// one output compare channel: match detect and pin action
`timescale 1ns/10ps
module tcmp_channel (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic countStep,
  input wire logic [tcmp_pkg::CNT_W-1:0] count,
  input wire logic [tcmp_pkg::CNT_W-1:0] compareValue,
  input wire logic [1:0] action,
  output logic chanOut,
  output logic matchPulse
);
  import tcmp_pkg::*;

  typedef struct packed {
    logic out;
    logic match;
  } ch_s;

  ch_s st_q;
  ch_s st_d;

  assign chanOut = st_q.out;
  assign matchPulse = st_q.match;

  // match only on a counting step so each count value fires once
  always_comb begin
    st_d = st_q;
    st_d.match = 1'b0;
    if (countStep && (count == compareValue)) begin
      st_d.match = 1'b1;
      case (action)
        ACT_NONE: st_d.out = st_q.out;
        ACT_TOGGLE: st_d.out = ~st_q.out;
        ACT_CLEAR: st_d.out = 1'b0;
        ACT_SET: st_d.out = 1'b1;
        default: st_d.out = st_q.out;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end
endmodule

/* design/timer_counter_output_compare.sv */
// top: 16-bit compare timer with AXI4-Lite register slave
// Summary of operation
// - the 16-bit counter counts up on each prescaled tick while enabled.
// - count writes are ignored unless special mode is asserted.
// - first period after a count write may be short or long.
// - run enable bit 7 clear stops the whole timer and counter.
// - divide-by-64 accumulator clock comes from the prescaler, absent when idle.
// - stop-in-wait bit 6 set halts the timer during wait mode.
// - stop-in-wait also halts the accumulator clock during wait.
// - mode/level pair picks none, toggle, clear or set on a compare.
// - mode or level set makes the pin an output from the channel.
// - a channel drives its pin only with its disconnect bit clear.
// - unimplemented control bits ignore writes and read as zero.
`timescale 1ns/10ps
module timer_counter_output_compare #(
  parameter int DIV = tcmp_pkg::PRESCALE_DIV,
  parameter int ACC = tcmp_pkg::ACC_DIV
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic specialMode,
  input wire logic waitMode,
  input wire logic [tcmp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tcmp_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tcmp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [tcmp_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [tcmp_pkg::NUM_CH-1:0] compareChannelOutput,
  output logic [tcmp_pkg::NUM_CH-1:0] compareOutputEnable,
  output logic [tcmp_pkg::NUM_CH-1:0] compareMatch,
  output logic accumulatorTick
);
  import tcmp_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic [7:0] sysCtl;
    logic [7:0] outCtl1;
    logic [7:0] outCtl2;
    logic [7:0] mask;
    logic [7:0] disc;
    logic [NUM_CH-1:0][CNT_W-1:0] cmp;
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [DATA_W-1:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [DATA_W-1:0] rData;
    logic [1:0] rResp;
  } top_s;

  top_s st_q;
  top_s st_d;

  logic timerActive;
  logic tick;
  logic [NUM_CH-1:0] chanOut;

  // register selected by an address, one-hot
  typedef enum logic [6:0] {
    SEL_COUNT = 7'h01,
    SEL_SYSCTL = 7'h02,
    SEL_OUTCTL1 = 7'h04,
    SEL_OUTCTL2 = 7'h08,
    SEL_PINCFG = 7'h10,
    SEL_CMP = 7'h20,
    SEL_NONE = 7'h40
  } reg_sel_e;

  // byte-lane merge of a write into an existing word
  function automatic logic [DATA_W-1:0] mergeBytes(
    input logic [DATA_W-1:0] old,
    input logic [DATA_W-1:0] data,
    input logic [3:0] strb
  );
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  // action code {mode,level} for one channel; channel 0..3 in ctl2, 4..7 in ctl1
  function automatic logic [1:0] chanAction(
    input logic [7:0] ctl1,
    input logic [7:0] ctl2,
    input int ch
  );
    logic [15:0] both;
    both = {ctl1, ctl2};
    return both[2*ch +: 2];
  endfunction

  // true when address falls in the compare window
  function automatic logic isCmp(input logic [ADDR_W-1:0] a);
    return (a >= OFS_CMP_BASE) && (a < OFS_CMP_BASE + 8'(4 * NUM_CH));
  endfunction

  // one decode shared by the write and read paths, so the two maps cannot drift
  function automatic reg_sel_e regSelect(input logic [ADDR_W-1:0] a);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (a == OFS_COUNT) begin
      sel = SEL_COUNT;
    end else if (a == OFS_SYSCTL) begin
      sel = SEL_SYSCTL;
    end else if (a == OFS_OUTCTL1) begin
      sel = SEL_OUTCTL1;
    end else if (a == OFS_OUTCTL2) begin
      sel = SEL_OUTCTL2;
    end else if (a == OFS_PINCFG) begin
      sel = SEL_PINCFG;
    end else if (isCmp(a)) begin
      sel = SEL_CMP;
    end
    return sel;
  endfunction

  // timer runs with run enable set, unless halted in wait mode
  assign timerActive = st_q.sysCtl[SC_RUN_BIT]
    && !(waitMode && st_q.sysCtl[SC_WAITSTOP_BIT]);

  tcmp_prescaler #(
    .DIV(DIV),
    .ACC(ACC)
  ) u_pre (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clkEn(clkEn),
    .active(timerActive),
    .tick(tick),
    .accTick(accumulatorTick)
  );

  // compare channels
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic [1:0] act;
    assign act = chanAction(st_q.outCtl1, st_q.outCtl2, g);
    tcmp_channel u_ch (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .clkEn(clkEn),
      .countStep(tick),
      .count(st_q.count),
      .compareValue(st_q.cmp[g]),
      .action(act),
      .chanOut(chanOut[g]),
      .matchPulse(compareMatch[g])
    );
    // pin is driven when mode or level set and not disconnected
    assign compareOutputEnable[g] = (act != ACT_NONE)
      && !st_q.disc[g];
  end

  assign compareChannelOutput = chanOut;

  // bus handshakes: accept each half once, answer when both held;
  // readies drop with the clock enable so no request is lost while frozen
  assign s_axi_awready = clkEn && !st_q.awHeld && !st_q.bValid;
  assign s_axi_wready = clkEn && !st_q.wHeld && !st_q.bValid;
  // limitation: a response taken while frozen is offered again
  assign s_axi_bvalid = st_q.bValid;
  assign s_axi_bresp = st_q.bResp;
  assign s_axi_arready = clkEn && !st_q.rValid;
  assign s_axi_rvalid = st_q.rValid;
  assign s_axi_rdata = st_q.rData;
  assign s_axi_rresp = st_q.rResp;

  // next state: counter, register writes, read mux
  always_comb begin
    logic [DATA_W-1:0] wd;
    logic [ADDR_W-1:0] ra;
    logic [2:0] idx;
    logic countWritten;
    wd = '0;
    ra = '0;
    idx = '0;
    countWritten = 1'b0;
    st_d = st_q;

    if (s_axi_awvalid && s_axi_awready) begin
      st_d.awHeld = 1'b1;
      st_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.wHeld = 1'b1;
      st_d.wData = s_axi_wdata;
      st_d.wStrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      st_d.bValid = 1'b0;
    end

    // perform write once both halves are held
    if (st_q.awHeld && st_q.wHeld) begin
      st_d.awHeld = 1'b0;
      st_d.wHeld = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp = RESP_OKAY;
      case (regSelect(st_q.awAddr))
        SEL_COUNT: begin
          // count writes only land in special mode; prescaler not realigned
          if (specialMode) begin
            wd = mergeBytes({16'h0000, st_q.count}, st_q.wData, st_q.wStrb);
            st_d.count = wd[CNT_W-1:0];
            countWritten = 1'b1;
          end
        end
        SEL_SYSCTL: begin
          wd = mergeBytes({24'h000000, st_q.sysCtl}, st_q.wData, st_q.wStrb);
          st_d.sysCtl = wd[7:0] & SC_IMPL_MASK;
        end
        SEL_OUTCTL1: begin
          wd = mergeBytes({24'h000000, st_q.outCtl1}, st_q.wData, st_q.wStrb);
          st_d.outCtl1 = wd[7:0];
        end
        SEL_OUTCTL2: begin
          wd = mergeBytes({24'h000000, st_q.outCtl2}, st_q.wData, st_q.wStrb);
          st_d.outCtl2 = wd[7:0];
        end
        SEL_PINCFG: begin
          wd = mergeBytes({16'h0000, st_q.disc, st_q.mask}, st_q.wData, st_q.wStrb);
          st_d.mask = wd[PC_MASK_LSB +: 8];
          st_d.disc = wd[PC_DISC_LSB +: 8];
        end
        SEL_CMP: begin
          idx = st_q.awAddr[4:2];
          wd = mergeBytes({16'h0000, st_q.cmp[idx]}, st_q.wData, st_q.wStrb);
          st_d.cmp[idx] = wd[CNT_W-1:0];
        end
        default: begin
          st_d.bResp = RESP_SLVERR;
        end
      endcase
    end

    // counter steps on a prescaler tick; a software write takes precedence
    if (tick && !countWritten) begin
      st_d.count = st_q.count + 16'h0001;
    end

    // read channel: answer one cycle after address taken
    if (s_axi_rvalid && s_axi_rready) begin
      st_d.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      ra = s_axi_araddr;
      st_d.rValid = 1'b1;
      st_d.rResp = RESP_OKAY;
      st_d.rData = '0;
      case (regSelect(ra))
        SEL_COUNT: begin
          st_d.rData = {16'h0000, st_q.count};
        end
        SEL_SYSCTL: begin
          st_d.rData = {24'h000000, st_q.sysCtl};
        end
        SEL_OUTCTL1: begin
          st_d.rData = {24'h000000, st_q.outCtl1};
        end
        SEL_OUTCTL2: begin
          st_d.rData = {24'h000000, st_q.outCtl2};
        end
        SEL_PINCFG: begin
          st_d.rData = {16'h0000, st_q.disc, st_q.mask};
        end
        SEL_CMP: begin
          idx = ra[4:2];
          st_d.rData = {16'h0000, st_q.cmp[idx]};
        end
        default: begin
          st_d.rResp = RESP_SLVERR;
        end
      endcase
    end
  end

  // state register; clock enable freezes everything
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.sysCtl <= SYSCTL_RST;
      st_q.outCtl1 <= OUTCTL_RST;
      st_q.outCtl2 <= OUTCTL_RST;
      st_q.mask <= MASK_RST;
      st_q.disc <= DISC_RST;
      st_q.cmp <= {NUM_CH{CMP_RST}};
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end
endmodule

/* bench/timer_counter_output_compare_properties.sv */
// checker: bus handshake and compare output properties of the timer
`timescale 1ns/10ps
module timer_counter_output_compare_properties (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] compareChannelOutput,
  input wire logic [7:0] compareMatch,
  input wire logic accumulatorTick
);
  // one domain, so clock and reset are declared once
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_resp_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_match_single: assert property (compareMatch != 8'h00 |=>
    (compareMatch & $past(compareMatch)) == 8'h00) else $error("match pulse too long");
  a_acc_spacing: assert property (accumulatorTick |=> !accumulatorTick [*8])
    else $error("accumulator ticks too close");
  a_action_cause: assert property ($changed(compareChannelOutput) |->
    (compareMatch != 8'h00 || $past(compareMatch) != 8'h00) or (##1 compareMatch != 8'h00))
    else $error("output moved without a match");
endmodule

bind timer_counter_output_compare timer_counter_output_compare_properties chk_inst (.*);

/* bench/timer_counter_output_compare_tb.sv */
// testbench: register map, counting, wait stop and compare actions
`timescale 1ns/10ps
module timer_counter_output_compare_tb;
  import tcmp_pkg::*;
  logic clk_sys, resetn, clkEn, specialMode, waitMode;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, accumulatorTick;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, d, c1;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [NUM_CH-1:0] compareChannelOutput, compareOutputEnable, compareMatch;
  int errors, tests_run, n, accs;
  typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] p;} row_s;
  row_s rows [7];
  logic [1:0] acts [5] = '{ACT_SET, ACT_CLEAR, ACT_TOGGLE, ACT_NONE, ACT_TOGGLE};
  logic outs [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  timer_counter_output_compare timer_counter_output_compare_inst (.*);

  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // counted on the falling edge so reads at rising edges never race it
  always @(negedge clk_sys) begin
    if (accumulatorTick === 1'b1) accs++;
  end

  task check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one bounded wait step; a hang ends the run
  task tick_wait;
    @(posedge clk_sys);
    n++;
    if (n > 200) begin
      errors++;
      $display("MISMATCH at %0t: wait ran out", $time);
      finish_test();
    end
  endtask
  // edge first, so bready is never raised in the step that lowered it
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      tick_wait();
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      tick_wait();
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // sample the tick count over a 130-cycle window; expect at least the given count
  task acc_window(input logic [31:0] e);
    c1 = accs;
    repeat (130) @(posedge clk_sys);
    check((accs - c1) >= e, 1'b1);
    if (e == 0) check(accs - c1, 0);
  endtask

  initial begin
    {resetn, specialMode, waitMode, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    clkEn = 1'b1;
    s_axi_wstrb = 4'hF;
    {errors, tests_run, accs} = '0;
    rows = '{'{OFS_SYSCTL, 32'h3F, 32'h0, RESP_OKAY}, '{OFS_COUNT, 32'h1234, 32'h0, RESP_OKAY},
      '{OFS_OUTCTL1, 32'hFFFFFFA5, 32'hA5, RESP_OKAY}, '{OFS_OUTCTL2, 32'h34, 32'h34, RESP_OKAY},
      '{OFS_PINCFG, 32'h1234FF00, 32'hFF00, RESP_OKAY},
      '{OFS_CMP_BASE, 32'hABCD0100, 32'h0100, RESP_OKAY}, '{8'h40, 32'h55, 32'h0, RESP_SLVERR}};
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(OFS_COUNT);
    check(d, 0);
    rd(OFS_SYSCTL);
    check(d, {24'h0, SYSCTL_RST});
    check(compareOutputEnable, 0);
    // register rows: write, answer, read back
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      check(r, rows[i].p);
      rd(rows[i].a);
      check(d, rows[i].e);
      check(r, rows[i].p);
    end
    check(compareOutputEnable, 0);
    wr(OFS_PINCFG, 0);
    check(compareOutputEnable, 8'hF6);
    wr(OFS_OUTCTL1, 0);
    specialMode <= 1'b1;
    // each pin action on channel 0, counting through its match
    for (int k = 0; k < 5; k++) begin
      wr(OFS_SYSCTL, 0);
      wr(OFS_OUTCTL2, {30'h0, acts[k]});
      wr(OFS_COUNT, 32'h00F8);
      wr(OFS_SYSCTL, 32'h80);
      n = 0;
      do tick_wait(); while (compareMatch[0] !== 1'b1);
      repeat (2) @(posedge clk_sys);
      check(compareChannelOutput[0], outs[k]);
      check(compareOutputEnable[0], acts[k] != ACT_NONE);
    end
    wr(OFS_SYSCTL, 0);
    wr(OFS_COUNT, 32'h1234);
    rd(OFS_COUNT);
    check(d, 32'h1234);
    acc_window(0);
    rd(OFS_COUNT);
    check(d, 32'h1234);
    // stop-in-wait set and processor waiting: counter and accumulator clock frozen
    waitMode <= 1'b1; // waiting before run is set, so no tick slips in
    wr(OFS_SYSCTL, 32'hC0);
    rd(OFS_COUNT);
    check(d, 32'h1234);
    acc_window(0);
    // stop-in-wait clear: keeps running through wait
    wr(OFS_SYSCTL, 32'h80);
    rd(OFS_COUNT);
    c1 = d;
    rd(OFS_COUNT);
    check(d != c1 && (d - c1) < 16, 1'b1);
    acc_window(2);
    // second reset in mid-run
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(OFS_SYSCTL);
    check(d, 0);
    rd(OFS_OUTCTL2);
    check(d, 0);
    finish_test();
  end
endmodule
